// ==== hw/lsa_pkg.sv ====
// Purpose: shared constants and types of the lmfc/sysref alignment monitor
// Assumes: 32-bit avalon-mm data, registers one word each at index * 4
// Notes: register indices kept as printed; byte address is index * 4
package lsa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam int IDX_LSB = 2;

  // register indices
  localparam logic [IDX_W-1:0] IDX_WINDOW = 10'h037;
  localparam logic [IDX_W-1:0] IDX_PREV_ERR_LOW = 10'h038;
  localparam logic [IDX_W-1:0] IDX_PREV_ERR_HIGH = 10'h039;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 10'h03A;
  localparam logic [IDX_W-1:0] IDX_ALIGN_STATUS = 10'h03B;
  localparam logic [IDX_W-1:0] IDX_CUR_ERR_LOW = 10'h03C;
  localparam logic [IDX_W-1:0] IDX_CUR_ERR_HIGH = 10'h03D;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h060;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 10'h061;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 10'h062;

  // field positions
  localparam int STAT_BUSY = 7;
  localparam int STAT_LOCK = 3;
  localparam int STAT_ROTATE = 2;
  localparam int STAT_OUTSIDE = 1;
  localparam int STAT_TRIP = 0;
  localparam int ERR_BELOW = 7;
  localparam int ERR_ABOVE = 6;
  localparam int CTL_ENABLE = 7;
  localparam int CTL_ARM = 6;
  localparam int CTL_CLR_STICKY = 5;
  localparam int CTL_CLR_PREV = 4;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_ROTATE = 1;
  localparam int IRQ_OUTSIDE = 2;
  localparam int IRQ_W = 3;

  // alignment mode codes
  localparam logic [3:0] MODE_ONE_SHOT = 4'h1;
  localparam logic [3:0] MODE_CONTINUOUS = 4'h2;
  localparam logic [3:0] MODE_MONITOR = 4'h8;
  localparam logic [3:0] MODE_ONE_SHOT_MON = 4'h9;

  // lmfc counter
  localparam int LMFC_CW = 8;
  localparam logic [LMFC_CW-1:0] LMFC_ALIGN_VAL = 8'h00;
  localparam logic signed [7:0] ERR_MAX = 8'sh07;
  localparam logic signed [7:0] ERR_MIN = -8'sh08;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    LSA_IDLE,
    LSA_ARMED,
    LSA_MONITOR
  } lsa_fsm_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } lsa_avs_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [DATA_W-1:0] readdata;
  } lsa_avs_rsp_t;

endpackage : lsa_pkg

// ==== hw/lsa_align_monitor.sv ====
// Purpose: lmfc to sysref phase alignment, status and phase-error reporting
// Assumes: sysref_i is asynchronous; avalon-mm slave with waitrequest
// Notes: all state lives in one packed struct registered in one process;
//   sysref is seen two edges after the pin, the result one edge later;
//   an adjust restarts the lmfc at the measuring edge, so that latency is
//   part of every error reported afterwards
//
// Overview of operation
// - mode 0b1001 aligns once, then monitors
// - busy at status bit 7 while machine runs
// - locked at status bit 3 inside window
// - sticky rotated at bit 2 on adjustment
// - bit 1 set when error outside window
// - sticky tripped at bit 0 on armed sysref
// - current error four-bit signed cycle count
// - adjustment copies error, zeroes current error
// - below flag at bit 7 of high register
// - above flag at bit 6 of high register
// - rising sticky clear clears rotated and tripped
// - rising previous clear clears previous record
// - error inside plus/minus window never adjusts
// - one-shot, continuous and monitor-only modes supported
`timescale 1ns/100ps
`default_nettype none

module lsa_align_monitor #(
  parameter int LMFC_PERIOD = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // avalon-mm slave
  input wire lsa_pkg::lsa_avs_req_t avs_req_i,
  output lsa_pkg::lsa_avs_rsp_t avs_rsp_o,
  // sysref and local multiframe clock
  input wire logic sysref_i,
  output logic lmfc_o,
  output logic adjust_o,
  // interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    // sysref synchroniser and edge history
    logic sref_meta;
    logic sref_sync;
    logic sref_prev;
    // lmfc
    logic [lsa_pkg::LMFC_CW-1:0] lmfc_cnt;
    logic lmfc;
    logic adjust;
    // machine
    lsa_pkg::lsa_fsm_t fsm;
    // software controls
    logic [1:0] window;
    logic [7:0] control;
    logic [7:0] control_prev;
    // status
    logic locked;
    logic rotated;
    logic outside;
    logic tripped;
    logic [3:0] cur_err;
    logic cur_below;
    logic cur_above;
    logic [3:0] prev_err;
    logic prev_below;
    logic prev_above;
    // interrupts
    logic [lsa_pkg::IRQ_W-1:0] irq_stat;
    logic [lsa_pkg::IRQ_W-1:0] irq_en;
    logic irq;
    // bus answer
    logic waitrequest;
    logic [lsa_pkg::DATA_W-1:0] readdata;
  } lsa_state_t;

  localparam lsa_state_t STATE_RST = '{
    fsm: lsa_pkg::LSA_IDLE,
    waitrequest: 1'b1,
    default: '0
  };

  localparam logic [lsa_pkg::LMFC_CW-1:0] PERIOD_LAST = lsa_pkg::LMFC_CW'(LMFC_PERIOD - 1);
  localparam logic [lsa_pkg::LMFC_CW-1:0] PERIOD_HALF = lsa_pkg::LMFC_CW'(LMFC_PERIOD / 2);
  localparam logic [lsa_pkg::LMFC_CW-1:0] PERIOD_VAL = lsa_pkg::LMFC_CW'(LMFC_PERIOD);
  // field widths within the byte-wide registers
  localparam int MODE_W = 4;
  localparam int WIN_W = 2;

  lsa_state_t st_reg;
  lsa_state_t st_next;

  logic sref_edge;
  logic measure;
  logic signed [7:0] err_wide;
  logic signed [7:0] err_clamp;
  logic signed [7:0] win_s;
  logic below;
  logic above;
  logic in_win;
  logic do_adjust;
  logic arm_rise;
  logic clr_sticky;
  logic clr_prev;
  logic bus_acc;
  logic wr_acc;
  logic byte0;
  logic [lsa_pkg::IDX_W-1:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [3:0] mode;
  logic [lsa_pkg::IRQ_W-1:0] irq_src;
  logic [lsa_pkg::IRQ_W-1:0] irq_evt;

  ////////////////////////////////////////////////////////////////////////////
  // phase measurement: error is the lmfc count at the sysref edge, folded
  // to a signed value about the lmfc edge
  // counts from half a period up read as early, the rest as late
  always_comb begin
    if (st_reg.lmfc_cnt >= PERIOD_HALF) begin
      err_wide = $signed(st_reg.lmfc_cnt - PERIOD_VAL);
    end else begin
      err_wide = $signed(st_reg.lmfc_cnt);
    end
    // saturate so a far-off edge still reads as the extreme error
    if (err_wide > lsa_pkg::ERR_MAX) begin
      err_clamp = lsa_pkg::ERR_MAX;
    end else if (err_wide < lsa_pkg::ERR_MIN) begin
      err_clamp = lsa_pkg::ERR_MIN;
    end else begin
      err_clamp = err_wide;
    end
    win_s = $signed({6'h00, st_reg.window});
    below = err_wide < -win_s;
    above = err_wide > win_s;
    in_win = !below && !above;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources: tripped at bit 0, rotated at bit 1, outside at bit 2; an event is raised only on the
  // measuring edge, so a held sysref level cannot retrigger it
  assign irq_src[lsa_pkg::IRQ_TRIP] = st_reg.fsm == lsa_pkg::LSA_ARMED;
  assign irq_src[lsa_pkg::IRQ_ROTATE] = do_adjust;
  assign irq_src[lsa_pkg::IRQ_OUTSIDE] = !in_win;
  for (genvar b = 0; b < lsa_pkg::IRQ_W; b++) begin : g_irq_evt
    assign irq_evt[b] = measure && irq_src[b];
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read mux
  // unmapped and write-only indices read as zero
  always_comb begin
    case (idx)
      lsa_pkg::IDX_WINDOW: rbyte = {6'h00, st_reg.window};
      lsa_pkg::IDX_PREV_ERR_LOW: rbyte = {4'h0, st_reg.prev_err};
      lsa_pkg::IDX_PREV_ERR_HIGH: rbyte = {st_reg.prev_below, st_reg.prev_above, 6'h00};
      lsa_pkg::IDX_CONTROL: rbyte = st_reg.control;
      lsa_pkg::IDX_ALIGN_STATUS: begin
        rbyte = 8'h00;
        rbyte[lsa_pkg::STAT_BUSY] = st_reg.fsm != lsa_pkg::LSA_IDLE;
        rbyte[lsa_pkg::STAT_LOCK] = st_reg.locked;
        rbyte[lsa_pkg::STAT_ROTATE] = st_reg.rotated;
        rbyte[lsa_pkg::STAT_OUTSIDE] = st_reg.outside;
        rbyte[lsa_pkg::STAT_TRIP] = st_reg.tripped;
      end
      lsa_pkg::IDX_CUR_ERR_LOW: rbyte = {4'h0, st_reg.cur_err};
      lsa_pkg::IDX_CUR_ERR_HIGH: rbyte = {st_reg.cur_below, st_reg.cur_above, 6'h00};
      lsa_pkg::IDX_IRQ_STATUS: rbyte = {5'h00, st_reg.irq_stat};
      lsa_pkg::IDX_IRQ_ENABLE: rbyte = {5'h00, st_reg.irq_en};
      default: rbyte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next = st_reg;
    idx = avs_req_i.address[lsa_pkg::IDX_LSB +: lsa_pkg::IDX_W];
    wbyte = avs_req_i.writedata[7:0];
    byte0 = avs_req_i.byteenable[0];
    mode = st_reg.control[MODE_W-1:0];

    // sysref passes two flops before any logic sees it
    st_next.sref_meta = sysref_i;
    st_next.sref_sync = st_reg.sref_meta;
    st_next.sref_prev = st_reg.sref_sync;
    sref_edge = st_reg.sref_sync && !st_reg.sref_prev;

    // bus: one idle wait cycle, then the answer with waitrequest low
    // the wait cycle buys a registered read mux at two cycles per access;
    // readdata is zero outside the answer so a stray sample reads nothing
    bus_acc = (avs_req_i.read || avs_req_i.write) && !st_reg.waitrequest;
    wr_acc = bus_acc && avs_req_i.write && byte0;
    st_next.waitrequest = !((avs_req_i.read || avs_req_i.write) && st_reg.waitrequest);
    st_next.readdata = '0;
    if ((avs_req_i.read || avs_req_i.write) && st_reg.waitrequest) begin
      st_next.readdata = {24'h000000, rbyte};
    end

    // software writes
    // every field sits in the low byte, so byte lane 0 must be enabled
    if (wr_acc) begin
      case (idx)
        lsa_pkg::IDX_WINDOW: st_next.window = wbyte[WIN_W-1:0];
        lsa_pkg::IDX_CONTROL: st_next.control = wbyte;
        lsa_pkg::IDX_IRQ_ENABLE: st_next.irq_en = wbyte[lsa_pkg::IRQ_W-1:0];
        lsa_pkg::IDX_IRQ_CLEAR: st_next.irq_stat = st_reg.irq_stat & ~wbyte[lsa_pkg::IRQ_W-1:0];
        default: st_next.window = st_next.window;
      endcase
    end

    // control strobes act on their rising edge
    st_next.control_prev = st_reg.control;
    arm_rise = st_reg.control[lsa_pkg::CTL_ARM] && !st_reg.control_prev[lsa_pkg::CTL_ARM];
    clr_sticky = st_reg.control[lsa_pkg::CTL_CLR_STICKY]
                 && !st_reg.control_prev[lsa_pkg::CTL_CLR_STICKY];
    clr_prev = st_reg.control[lsa_pkg::CTL_CLR_PREV]
               && !st_reg.control_prev[lsa_pkg::CTL_CLR_PREV];
    if (clr_sticky) begin
      st_next.rotated = 1'b0;
      st_next.tripped = 1'b0;
    end
    if (clr_prev) begin
      st_next.prev_err = 4'h0;
      st_next.prev_below = 1'b0;
      st_next.prev_above = 1'b0;
    end

    // free-running lmfc
    // an adjust below overrides this count; the wrap compare uses >= so a
    // count left out of range by a smaller period still returns to zero
    if (st_reg.lmfc_cnt >= PERIOD_LAST) begin
      st_next.lmfc_cnt = '0;
    end else begin
      st_next.lmfc_cnt = st_reg.lmfc_cnt + lsa_pkg::LMFC_CW'(1);
    end
    st_next.lmfc = st_next.lmfc_cnt < PERIOD_HALF;

    // alignment machine
    measure = 1'b0;
    do_adjust = 1'b0;
    case (st_reg.fsm)
      lsa_pkg::LSA_IDLE: begin
        // only the rising edge of arm counts, so a held arm bit does not
        // re-arm after a one-shot; sysref while idle trips nothing
        if (arm_rise && st_reg.control[lsa_pkg::CTL_ENABLE]) begin
          st_next.fsm = lsa_pkg::LSA_ARMED;
        end
      end
      lsa_pkg::LSA_ARMED: begin
        if (sref_edge) begin
          measure = 1'b1;
          st_next.tripped = 1'b1;
          case (mode)
            lsa_pkg::MODE_ONE_SHOT: begin
              do_adjust = !in_win;
              st_next.fsm = lsa_pkg::LSA_IDLE;
            end
            lsa_pkg::MODE_ONE_SHOT_MON: begin
              do_adjust = !in_win;
              st_next.fsm = lsa_pkg::LSA_MONITOR;
            end
            lsa_pkg::MODE_CONTINUOUS: begin
              do_adjust = !in_win;
              st_next.fsm = lsa_pkg::LSA_MONITOR;
            end
            lsa_pkg::MODE_MONITOR: st_next.fsm = lsa_pkg::LSA_MONITOR;
            // unknown mode codes trip but leave the machine idle
            default: st_next.fsm = lsa_pkg::LSA_IDLE;
          endcase
        end
      end
      lsa_pkg::LSA_MONITOR: begin
        if (sref_edge) begin
          measure = 1'b1;
          // one-shot-then-monitor and monitor-only never adjust here
          do_adjust = (mode == lsa_pkg::MODE_CONTINUOUS) && !in_win;
        end
        if (arm_rise) begin
          st_next.fsm = lsa_pkg::LSA_ARMED;
        end
      end
      default: st_next.fsm = lsa_pkg::LSA_IDLE;
    endcase
    // disabling stops the machine at once; flags keep their last value
    if (!st_reg.control[lsa_pkg::CTL_ENABLE]) begin
      st_next.fsm = lsa_pkg::LSA_IDLE;
    end

    // locked and outside come from one compare, so they are never both set
    if (measure) begin
      st_next.locked = in_win;
      st_next.outside = !in_win;
      if (do_adjust) begin
        st_next.lmfc_cnt = lsa_pkg::LMFC_ALIGN_VAL;
        st_next.lmfc = 1'b1;
        st_next.rotated = 1'b1;
        st_next.prev_err = err_clamp[3:0];
        st_next.prev_below = below;
        st_next.prev_above = above;
        st_next.cur_err = 4'h0;
        st_next.cur_below = 1'b0;
        st_next.cur_above = 1'b0;
      end else begin
        st_next.cur_err = err_clamp[3:0];
        st_next.cur_below = below;
        st_next.cur_above = above;
      end
    end
    st_next.adjust = do_adjust;

    // interrupt: events set after any clear so a same-cycle event survives
    st_next.irq_stat = st_next.irq_stat | irq_evt;
    // the level output takes the next state, so it leaves a flop
    st_next.irq = |(st_next.irq_stat & st_next.irq_en);
  end

  ////////////////////////////////////////////////////////////////////////////
  // asynchronous clear to constants only
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // every output is a bit of the registered state
  assign avs_rsp_o.waitrequest = st_reg.waitrequest;
  assign avs_rsp_o.readdata = st_reg.readdata;
  assign lmfc_o = st_reg.lmfc;
  assign adjust_o = st_reg.adjust;
  assign irq_o = st_reg.irq;

endmodule : lsa_align_monitor

`default_nettype wire

// ==== verification/lsa_align_assertions.sv ====
// Purpose: bus and status field checks of the alignment monitor
// Assumes: bound to lsa_align_monitor, one clock domain
// Notes: sysref to adjust latency is allowed a window of 3 to 5 edges
`timescale 1ns/100ps
`default_nettype none
module lsa_align_assertions (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // avalon-mm slave
  input wire lsa_pkg::lsa_avs_req_t avs_req_i,
  input wire lsa_pkg::lsa_avs_rsp_t avs_rsp_o,
  // sysref, lmfc and interrupt
  input wire logic sysref_i,
  input wire logic lmfc_o,
  input wire logic adjust_o,
  input wire logic irq_o
);
  logic rd_ok;
  logic [lsa_pkg::IDX_W-1:0] idx;
  logic [31:0] rd;
  assign rd_ok = avs_req_i.read && !avs_rsp_o.waitrequest;
  assign idx = avs_req_i.address[11:2];
  assign rd = avs_rsp_o.readdata;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////////
  a_wait_answer: assert property ((avs_req_i.read || avs_req_i.write) && avs_rsp_o.waitrequest
    |=> !avs_rsp_o.waitrequest) else $error("no answer one cycle after request");
  a_wait_single: assert property (!avs_rsp_o.waitrequest |=> avs_rsp_o.waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_data_idle: assert property (avs_rsp_o.waitrequest |-> rd == 32'h0)
    else $error("read data not zero outside an answer");
  a_upper_zero: assert property (rd_ok |-> rd[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_status_spare: assert property (rd_ok && idx == lsa_pkg::IDX_ALIGN_STATUS |-> rd[6:4] == 3'h0)
    else $error("status spare bits set");
  a_lock_exclusive: assert property (rd_ok && idx == lsa_pkg::IDX_ALIGN_STATUS |-> !(rd[3] && rd[1]))
    else $error("locked and outside set together");
  a_error_width: assert property (rd_ok && idx == lsa_pkg::IDX_CUR_ERR_LOW |-> rd[7:4] == 4'h0)
    else $error("current error wider than four bits");
  a_flag_field: assert property (rd_ok && idx == lsa_pkg::IDX_CUR_ERR_HIGH |-> rd[5:0] == 6'h0 && !(rd[7] && rd[6]))
    else $error("current flags malformed");
  a_adjust_pulse: assert property ($rose(adjust_o) |=> !adjust_o)
    else $error("adjust longer than one cycle");
  a_adjust_cause: assert property (adjust_o |-> $past(sysref_i, 3) || $past(sysref_i, 4) || $past(sysref_i, 5))
    else $error("adjust without a sysref pulse");
endmodule : lsa_align_assertions
`default_nettype wire

// ==== verification/lsa_sysref_source.sv ====
// Purpose: sysref source that fires a pulse a set gap after its previous one
// Assumes: gap counted in clock cycles between pulse rises
// Notes: fires at once if the gap has already passed when asked
`timescale 1ns/100ps
`default_nettype none
module lsa_sysref_source (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // request from bench
  input wire logic go_i,
  input wire logic [15:0] gap_i,
  // sysref pin
  output logic sysref_o,
  output logic fired_o
);
  logic [15:0] cnt_reg;
  logic [1:0] hold_reg;
  // two cycles high so the two-flop synchroniser cannot miss the pulse
  assign sysref_o = |hold_reg;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 16'h0000;
      hold_reg <= 2'h0;
      fired_o <= 1'h0;
    end else begin
      fired_o <= 1'h0;
      hold_reg <= {hold_reg[0], 1'h0};
      if (cnt_reg != 16'hFFFF) cnt_reg <= cnt_reg + 16'h0001;
      if (go_i && cnt_reg >= gap_i) begin
        hold_reg <= 2'h3;
        cnt_reg <= 16'h0001;
        fired_o <= 1'h1;
      end
    end
  end
endmodule : lsa_sysref_source
`default_nettype wire

// ==== verification/lsa_align_monitor_tb.sv ====
// Purpose: self-checking bench of the lmfc/sysref alignment monitor
// Assumes: phase error counted from the last adjusting pulse, period 16
// Notes: first pulse is unknown in phase, so it only forces alignment and the second is checked
`timescale 1ns/100ps
`default_nettype none
module lsa_align_monitor_tb;
  logic clock_i = 1'h0;
  logic nrst_i = 1'h0;
  lsa_pkg::lsa_avs_req_t req = '0;
  lsa_pkg::lsa_avs_rsp_t rsp;
  logic sysref, lmfc, adj, irq, fired;
  logic go = 1'h0;
  logic [15:0] gap = 16'h0000;
  logic [41:0] expq[$];
  int err_total = 0;
  int check_count = 0;
  int ph = 0;
  int d;
  logic [9:0] reset_idx [6] = '{lsa_pkg::IDX_ALIGN_STATUS, lsa_pkg::IDX_CUR_ERR_LOW,
    lsa_pkg::IDX_CUR_ERR_HIGH, lsa_pkg::IDX_PREV_ERR_LOW, lsa_pkg::IDX_IRQ_CLEAR, 10'h3FF};
  logic [3:0] modes [3] = '{lsa_pkg::MODE_MONITOR, lsa_pkg::MODE_ONE_SHOT,
    lsa_pkg::MODE_ONE_SHOT_MON};
  always #10 clock_i = ~clock_i;
  lsa_align_monitor #(.LMFC_PERIOD(16)) dut (.clock_i(clock_i), .nrst_i(nrst_i),
    .avs_req_i(req), .avs_rsp_o(rsp), .sysref_i(sysref), .lmfc_o(lmfc), .adjust_o(adj),
    .irq_o(irq));
  lsa_sysref_source src (.clock_i(clock_i), .nrst_i(nrst_i), .go_i(go), .gap_i(gap),
    .sysref_o(sysref), .fired_o(fired));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
    input logic [3:0] be);
    int n;
    @(posedge clock_i);
    req <= '{read: !wr, write: wr, address: {idx, 2'h0}, writedata: wd, byteenable: be};
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (rsp.waitrequest !== 1'h0 && n < 20);
    if (rsp.waitrequest !== 1'h0) begin
      err_total++;
      print_verdict();
    end
    req <= '0;
  endtask : bus
  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    bus(1'h1, idx, wd, 4'hF);
  endtask : wr
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    expq.push_back({idx, exp});
    bus(1'h0, idx, 32'h0, 4'hF);
  endtask : rd
  // a pulse err cycles off the aligned phase; measurement lands within 5 edges
  task automatic pulse(input int err, input logic adjusts);
    int n;
    @(posedge clock_i);
    gap <= 16'(64 + err - ph);
    go <= 1'h1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (fired !== 1'h1 && n < 200);
    if (fired !== 1'h1) begin
      err_total++;
      print_verdict();
    end
    go <= 1'h0;
    repeat (8) @(posedge clock_i);
    // an adjust restarts the lmfc at the measuring edge, one edge after the
    // pulse's own phase point, so the next gap counts from minus one
    ph = adjusts ? -1 : err;
  endtask : pulse
  // read results are compared here, oldest note first
  always @(posedge clock_i) begin
    if (req.read && rsp.waitrequest === 1'h0) begin
      check($sformatf("reg %h", expq[0][41:32]), rsp.readdata, expq[0][31:0]);
      void'(expq.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(21476));
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'h1;
    repeat (3) @(posedge clock_i);
    foreach (reset_idx[i]) rd(reset_idx[i], 32'h0);
    wr(lsa_pkg::IDX_IRQ_ENABLE, 32'h7);
    wr(lsa_pkg::IDX_WINDOW, 32'h0);
    wr(lsa_pkg::IDX_CONTROL, 32'h82);
    wr(lsa_pkg::IDX_CONTROL, 32'hC2);
    pulse(0, 1'h1);
    pulse(2, 1'h1);
    rd(lsa_pkg::IDX_ALIGN_STATUS, 32'h87);
    rd(lsa_pkg::IDX_CUR_ERR_LOW, 32'h0);
    rd(lsa_pkg::IDX_PREV_ERR_LOW, 32'h2);
    rd(lsa_pkg::IDX_PREV_ERR_HIGH, 32'h40);
    rd(lsa_pkg::IDX_IRQ_STATUS, 32'h7);
    check("irq_o", irq, 32'h1);
    wr(lsa_pkg::IDX_IRQ_CLEAR, 32'h7);
    rd(lsa_pkg::IDX_IRQ_STATUS, 32'h0);
    check("irq_o", irq, 32'h0);
    wr(lsa_pkg::IDX_WINDOW, 32'h1);
    bus(1'h1, lsa_pkg::IDX_WINDOW, 32'h3, 4'h0);
    rd(lsa_pkg::IDX_WINDOW, 32'h1);
    d = $urandom_range(2) - 1;
    pulse(d, 1'h0);
    rd(lsa_pkg::IDX_ALIGN_STATUS, 32'h8D);
    rd(lsa_pkg::IDX_CUR_ERR_LOW, 32'(d) & 32'hF);
    rd(lsa_pkg::IDX_CUR_ERR_HIGH, 32'h0);
    pulse(-3, 1'h1);
    rd(lsa_pkg::IDX_PREV_ERR_LOW, 32'hD);
    rd(lsa_pkg::IDX_PREV_ERR_HIGH, 32'h80);
    wr(lsa_pkg::IDX_CONTROL, 32'hA2);
    rd(lsa_pkg::IDX_ALIGN_STATUS, 32'h82);
    wr(lsa_pkg::IDX_CONTROL, 32'h92);
    rd(lsa_pkg::IDX_PREV_ERR_LOW, 32'h0);
    rd(lsa_pkg::IDX_PREV_ERR_HIGH, 32'h0);
    wr(lsa_pkg::IDX_IRQ_ENABLE, 32'h0);
    foreach (modes[i]) begin
      wr(lsa_pkg::IDX_CONTROL, {24'h0, 4'hA, modes[i]});
      wr(lsa_pkg::IDX_CONTROL, {24'h0, 4'hC, modes[i]});
      pulse(4, modes[i] != 4'h8);
      rd(lsa_pkg::IDX_ALIGN_STATUS, {24'h0, modes[i] != 4'h1, 4'h0, modes[i] != 4'h8, 2'h3});
      rd(lsa_pkg::IDX_CUR_ERR_LOW, (modes[i] == 4'h8) ? 32'h4 : 32'h0);
      if (i == 0) begin
        check("irq_o", irq, 32'h0);
        wr(lsa_pkg::IDX_IRQ_ENABLE, 32'h7);
        rd(lsa_pkg::IDX_IRQ_ENABLE, 32'h7);
        check("irq_o", irq, 32'h1);
      end
    end
    pulse(4, 1'h0);
    rd(lsa_pkg::IDX_ALIGN_STATUS, 32'h87);
    rd(lsa_pkg::IDX_CUR_ERR_LOW, 32'h4);
    rd(lsa_pkg::IDX_CUR_ERR_HIGH, 32'h40);
    print_verdict();
  end
endmodule : lsa_align_monitor_tb
bind lsa_align_monitor lsa_align_assertions u_chk (.clock_i(clock_i), .nrst_i(nrst_i),
  .avs_req_i(avs_req_i), .avs_rsp_o(avs_rsp_o), .sysref_i(sysref_i), .lmfc_o(lmfc_o),
  .adjust_o(adjust_o), .irq_o(irq_o));
`default_nettype wire
